// ==== inc/pwr_mode_pkg.sv ====
// Power-down mode control package: register map, field positions, reset values, modes.
// Assumes a 32-bit Avalon-MM register bus with word addressing in bytes.
package pwr_mode_pkg;

  // Register byte offsets
  localparam logic [3:0] module_stop_off = 4'h0;
  localparam logic [3:0] standby_ctrl_off = 4'h4;
  localparam logic [3:0] low_power_off = 4'h8;
  localparam logic [3:0] status_off = 4'hc;

  // Reset values
  localparam logic [15:0] module_stop_reset = 16'h3fff;
  localparam logic [7:0] standby_ctrl_reset = 8'h00;
  localparam logic [7:0] low_power_reset = 8'h00;

  // Standby control fields
  localparam int sck_lsb = 0;
  localparam int sts_lsb = 4;
  localparam int software_standby_select_bit = 7;
  // Low power control fields
  localparam int low_speed_on_bit = 0;
  localparam int direct_transfer_on_bit = 1;
  localparam int pss_bit = 2;
  // Module stop fields
  localparam int conv_stop_bit = 9;

  // Settling time base, in phi cycles, shifted left by the standby timer select code
  localparam logic [7:0] settle_unit = 8'h10;

  // Wake sources: second watchdog, NMI, five external lines
  localparam int wake_n = 7;

  typedef enum logic [2:0] {
    mode_active,
    mode_sleep,
    mode_sw_standby,
    mode_watch,
    mode_settle,
    mode_subactive
  } pwr_mode_t;

endpackage

// ==== design/power_down_mode_control.sv ====
// Power-down mode control: module stop bits, medium-speed clock division,
// sleep, software standby and watch modes with their exits.
// Assumes the CPU pulses sleep_exec at an instruction and bus_cycle_end at each
// bus cycle boundary; the watchdog reset arrives as a synchronous pulse.
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module power_down_mode_control
  import pwr_mode_pkg::*;
#(
  parameter int stop_bits = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Pins and reset sources
  input wire logic hardware_standby_pin_n,
  input wire logic watchdog_reset,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // CPU side
  input wire logic sleep_exec,
  input wire logic bus_cycle_end,
  output logic cpu_clk_en,
  output logic dtc_clk_en,
  output logic periph_clk_en,
  output logic watchdog2_clk_en,
  output logic port_hold,
  output logic interrupt_start,
  // Wake sources: 0 watchdog, 1 nmi, 2..6 external lines 0,1,2,6,7
  input wire logic [wake_n-1:0] wake_req,
  input wire logic [wake_n-1:0] wake_enable,
  input wire logic cpu_mask,
  // Module stop outputs, plus converter stop and per-module access gate
  output logic [stop_bits-1:0] module_stop,
  output logic converter_stop,
  input wire logic [stop_bits-1:0] module_access,
  output logic [stop_bits-1:0] module_access_ok
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] module_stop_control_reg;
  logic [7:0] standby_control_register_reg;
  logic [7:0] low_power_control_register_reg;
  logic [2:0] active_div_reg;
  logic [4:0] div_cnt_reg;
  logic [11:0] settle_cnt_reg;
  logic converter_stop_reg;
  logic rd_ack_reg;
  pwr_mode_t mode_reg;
  logic hw_standby;
  logic sync_reset;
  logic wr_ok;
  logic [2:0] system_clock_select;
  logic [2:0] standby_timer_select;
  logic software_standby_select;
  logic low_speed_on;
  logic direct_transfer_on;
  logic watchdog_prescaler_select;
  logic [wake_n-1:0] wake_gated;
  logic watch_wake;
  logic ext_wake;
  logic div_tick;
  logic [4:0] div_mask;
  logic [11:0] settle_target;

  assign hw_standby = !hardware_standby_pin_n;
  assign sync_reset = hw_standby || watchdog_reset;
  assign system_clock_select = standby_control_register_reg[sck_lsb +: 3];
  assign standby_timer_select = standby_control_register_reg[sts_lsb +: 3];
  assign software_standby_select = standby_control_register_reg[software_standby_select_bit];
  assign low_speed_on = low_power_control_register_reg[low_speed_on_bit];
  assign direct_transfer_on = low_power_control_register_reg[direct_transfer_on_bit];
  assign watchdog_prescaler_select = low_power_control_register_reg[pss_bit];
  // Disabled sources never wake; masked ones wake only from sleep; NMI ignores the CPU mask
  assign wake_gated = wake_req & wake_enable & {{(wake_n-2){!cpu_mask}}, 1'b1, !cpu_mask};
  assign watch_wake = |wake_gated;
  assign ext_wake = |wake_gated[wake_n-1:1];

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: zero wait on writes, one wait state on reads
  assign waitrequest = read && !rd_ack_reg;
  assign wr_ok = write && !hw_standby;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_ack_reg <= 1'b0;
    end else begin
      rd_ack_reg <= read && !rd_ack_reg;
    end
  end

  // Read data registered; unmapped offsets read as zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !rd_ack_reg) begin
      unique case (address)
        module_stop_off: readdata <= {16'h0000, module_stop_control_reg};
        standby_ctrl_off: readdata <= {24'h000000, standby_control_register_reg};
        low_power_off: readdata <= {24'h000000, low_power_control_register_reg};
        status_off: readdata <= {29'h0000000, mode_reg};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Module stop register: hardware standby reloads, software standby keeps
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      module_stop_control_reg <= module_stop_reset;
    end else if (hw_standby) begin
      module_stop_control_reg <= module_stop_reset;
    end else if (wr_ok && address == module_stop_off) begin
      if (byteenable[0]) module_stop_control_reg[7:0] <= writedata[7:0];
      if (byteenable[1]) module_stop_control_reg[15:8] <= writedata[15:8];
    end
  end

  // Standby and low-power control; watchdog reset clears speed selection too
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      standby_control_register_reg <= standby_ctrl_reset;
      low_power_control_register_reg <= low_power_reset;
    end else if (sync_reset) begin
      standby_control_register_reg <= standby_ctrl_reset;
      low_power_control_register_reg <= low_power_reset;
    end else if (wr_ok && byteenable[0]) begin
      if (address == standby_ctrl_off) standby_control_register_reg <= writedata[7:0];
      if (address == low_power_off) low_power_control_register_reg <= writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-module stop and access gating
  genvar gi;
  generate
    for (gi = 0; gi < stop_bits; gi++) begin : g_stop
      assign module_stop[gi] = (gi == conv_stop_bit) ? converter_stop_reg
                             : module_stop_control_reg[gi];
      assign module_access_ok[gi] = module_access[gi] && !module_stop[gi];
    end
  endgenerate
  assign converter_stop = converter_stop_reg;

  // Converter stops once the running bus cycle is over; hardware standby stops it at once
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      converter_stop_reg <= 1'b1;
    end else if (hw_standby) begin
      converter_stop_reg <= 1'b1;
    end else if (bus_cycle_end) begin
      converter_stop_reg <= module_stop_control_reg[conv_stop_bit];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Division ratio follows the select field only at bus cycle boundaries; a synchronous reset clears it at once
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      active_div_reg <= 3'h0;
    end else if (sync_reset) begin
      active_div_reg <= 3'h0;
    end else if (bus_cycle_end && div_tick) begin
      active_div_reg <= (system_clock_select > 3'h5) ? 3'h5 : system_clock_select;
    end
  end

  // Free counter; a tick every 2^n phi cycles so no period is cut short
  assign div_mask = 5'((6'h01 << active_div_reg) - 6'h01);
  assign div_tick = (div_cnt_reg & div_mask) == div_mask;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_reg <= 5'h00;
    end else if (div_tick) begin
      div_cnt_reg <= 5'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode sequencer
  // Wide enough for the longest code: 16 shifted by 7 needs twelve bits
  assign settle_target = {4'h0, settle_unit} << standby_timer_select;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= mode_active;
      settle_cnt_reg <= 12'h000;
    end else if (sync_reset) begin
      mode_reg <= mode_active;
      settle_cnt_reg <= 12'h000;
    end else begin
      unique case (mode_reg)
        mode_active, mode_subactive: begin
          if (sleep_exec) begin
            if (software_standby_select && !direct_transfer_on && watchdog_prescaler_select)
              mode_reg <= mode_watch;
            else if (software_standby_select && !low_speed_on && !watchdog_prescaler_select)
              mode_reg <= mode_sw_standby;
            else if (!software_standby_select && !low_speed_on)
              mode_reg <= mode_sleep;
          end
        end
        mode_sleep: if (|(wake_req & wake_enable)) mode_reg <= mode_active;
        // Count restarts at zero, else a stale count from a watch exit cuts settling short
        mode_sw_standby: begin
          if (ext_wake) begin
            settle_cnt_reg <= 12'h000;
            mode_reg <= mode_settle;
          end
        end
        mode_watch: begin
          if (watch_wake) begin
            settle_cnt_reg <= 12'h000;
            mode_reg <= low_speed_on ? mode_subactive : mode_settle;
          end
        end
        mode_settle: begin
          settle_cnt_reg <= settle_cnt_reg + 12'h001;
          if (settle_cnt_reg + 12'h001 >= settle_target) mode_reg <= mode_active;
        end
        default: mode_reg <= mode_active;
      endcase
    end
  end

  // One-cycle pulse when clocks return after settling
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_start <= 1'b0;
    end else begin
      interrupt_start <= !sync_reset && mode_reg == mode_settle
                         && settle_cnt_reg + 12'h001 >= settle_target;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock enables: bus masters divided, others full rate
  logic running;
  logic stopped_all;
  assign running = (mode_reg == mode_active || mode_reg == mode_subactive) && !hw_standby;
  assign stopped_all = mode_reg == mode_watch || mode_reg == mode_sw_standby
                       || mode_reg == mode_settle || hw_standby;
  assign cpu_clk_en = running && div_tick;
  assign dtc_clk_en = (running || mode_reg == mode_sleep) && div_tick;
  assign periph_clk_en = !stopped_all;
  assign watchdog2_clk_en = !hw_standby;
  assign port_hold = mode_reg == mode_watch || mode_reg == mode_sw_standby;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property reg_reset_p;
    @(posedge core_clk) disable iff (!nrst) hw_standby |=> module_stop_control_reg == 16'h3fff;
  endproperty
  module_stop_reset_a: assert property (reg_reset_p) else $error("stop reg not reloaded");

  converter_edge_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !bus_cycle_end && !hw_standby |=> $stable(converter_stop_reg))
    else $error("converter stop changed mid cycle");

  access_gate_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (module_access_ok & module_stop) == '0) else $error("stopped module accessed");

  ratio_bound_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !bus_cycle_end && !sync_reset |=> $stable(active_div_reg))
    else $error("ratio changed off boundary");

  wdt_cancel_a: assert property (@(posedge core_clk) disable iff (!nrst)
    watchdog_reset |=> active_div_reg == 3'h0 && mode_reg == mode_active)
    else $error("watchdog reset kept medium speed");

  sequence watch_entry_s;
    mode_reg == mode_active && sleep_exec && software_standby_select
      && !direct_transfer_on && watchdog_prescaler_select && !sync_reset;
  endsequence
  watch_enter_a: assert property (@(posedge core_clk) disable iff (!nrst)
    watch_entry_s |=> mode_reg == mode_watch) else $error("watch not entered");

  watch_stop_a: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_reg == mode_watch && !hw_standby
      |-> !cpu_clk_en && !periph_clk_en && port_hold && watchdog2_clk_en)
    else $error("watch clocks wrong");

  mask_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_reg == mode_watch && wake_gated == '0 && !sync_reset |=> mode_reg == mode_watch)
    else $error("watch left without source");

  low_speed_on_exit_a: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_reg == mode_watch && watch_wake && low_speed_on && !sync_reset
      |=> mode_reg == mode_subactive) else $error("subactive not chosen");

  hw_hardware_standby_pin_a: assert property (@(posedge core_clk) disable iff (!nrst)
    hw_standby |-> !cpu_clk_en && !periph_clk_en) else $error("standby not immediate");

  sleep_enter_a: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_reg == mode_active && sleep_exec && !software_standby_select && !low_speed_on
      && !sync_reset |=> mode_reg == mode_sleep) else $error("sleep not entered");

  standby_enter_a: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_reg == mode_active && sleep_exec && software_standby_select && !low_speed_on
      && !watchdog_prescaler_select && !sync_reset |=> mode_reg == mode_sw_standby)
    else $error("standby not entered");

  settle_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_reg == mode_settle && settle_cnt_reg + 12'h001 < settle_target && !sync_reset
      |=> mode_reg == mode_settle && !interrupt_start) else $error("settling cut short");

endmodule
`default_nettype wire

// ==== testbench/cpu_side_model.sv ====
// Cpu side model: sleep instruction pulses, bus cycle boundaries, wake lines.
// Assumes the bench requests sleep and wake levels on rising clock edges.
`timescale 1ns/100ps
`default_nettype none
module cpu_side_model
  import pwr_mode_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bench requests
  input wire logic sleep_go,
  input wire logic slow,
  input wire logic [wake_n-1:0] wake_set,
  // Towards the block
  output logic sleep_exec,
  output logic bus_cycle_end,
  output logic [wake_n-1:0] wake_req
);
  logic [2:0] cyc_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles of 4 or, when slow, 7 clocks; odd length hunts divider phases
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cyc_reg <= 3'h0;
    end else begin
      cyc_reg <= (cyc_reg >= (slow ? 3'h6 : 3'h3)) ? 3'h0 : cyc_reg + 3'h1;
    end
  end
  assign bus_cycle_end = (cyc_reg == 3'h0);
  // Sleep pulse and wake lines, one register stage like a real sync
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sleep_exec <= 1'b0;
      wake_req <= '0;
    end else begin
      sleep_exec <= sleep_go;
      wake_req <= wake_set;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench: Avalon-MM master, read notes in a queue, mode checks.
// Assumes the cpu side model drives sleep, bus cycle and wake inputs.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pwr_mode_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic hardware_standby_pin_n = 1'b1;
  logic watchdog_reset = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, sleep_exec, bus_cycle_end, cpu_clk_en, dtc_clk_en, periph_clk_en;
  logic watchdog2_clk_en, port_hold, interrupt_start, converter_stop;
  logic sleep_go = 1'b0;
  logic slow = 1'b0;
  logic cpu_mask = 1'b0;
  logic [wake_n-1:0] wake_set = '0;
  logic [wake_n-1:0] wake_enable = '1;
  logic [wake_n-1:0] wake_req;
  logic [15:0] module_stop, module_access_ok, d;
  logic [15:0] module_access = 16'h0;
  logic [15:0] exp_q[$];
  logic [31:0] lfsr_state = 32'd76361;
  int error_cnt = 0;
  int cmp_count = 0;
  int n_cpu, n_dtc, n_per;
  always #20 core_clk = ~core_clk;
  power_down_mode_control u_dut (.core_clk(core_clk), .nrst(nrst),
    .hardware_standby_pin_n(hardware_standby_pin_n), .watchdog_reset(watchdog_reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .sleep_exec(sleep_exec), .bus_cycle_end(bus_cycle_end), .cpu_clk_en(cpu_clk_en),
    .dtc_clk_en(dtc_clk_en), .periph_clk_en(periph_clk_en),
    .watchdog2_clk_en(watchdog2_clk_en), .port_hold(port_hold),
    .interrupt_start(interrupt_start), .wake_req(wake_req), .wake_enable(wake_enable),
    .cpu_mask(cpu_mask), .module_stop(module_stop), .converter_stop(converter_stop),
    .module_access(module_access), .module_access_ok(module_access_ok));
  cpu_side_model u_cpu (.core_clk(core_clk), .nrst(nrst), .sleep_go(sleep_go),
    .slow(slow), .wake_set(wake_set), .sleep_exec(sleep_exec),
    .bus_cycle_end(bus_cycle_end), .wake_req(wake_req));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hold the request until waitrequest is seen low; unbounded wait
  // Only the watchdog below ends a wait that never completes
  task automatic bus_wait;
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    address <= a;
    writedata <= {16'h0, v};
    write <= 1'b1;
    bus_wait();
    write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    address <= a;
    read <= 1'b1;
    bus_wait();
    read <= 1'b0;
    @(posedge core_clk);
  endtask
  // Count clock enables over n cycles, sampled mid-cycle
  task automatic count_en(input int n);
    n_cpu = 0;
    n_dtc = 0;
    n_per = 0;
    repeat (n) begin
      @(negedge core_clk);
      n_cpu += (cpu_clk_en === 1'b1);
      n_dtc += (dtc_clk_en === 1'b1);
      n_per += (periph_clk_en === 1'b1);
    end
    @(posedge core_clk);
  endtask
  task automatic do_sleep;
    sleep_go <= 1'b1;
    @(posedge core_clk);
    sleep_go <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wake(input logic [wake_n-1:0] w);
    wake_set <= w;
    repeat (3) @(posedge core_clk);
    wake_set <= '0;
    repeat (2) @(posedge core_clk);
  endtask
  // Read data taken at the edge that completes the read
  always @(posedge core_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) error_cnt++;
      else chk("readdata", readdata[15:0], exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(module_stop_off, module_stop_reset);
    rd(standby_ctrl_off, 16'h0);
    rd(low_power_off, 16'h0);
    rd(4'h2, 16'h0);
    for (int i = 0; i < 4; i++) begin
      lfsr_state = lfsr_next(lfsr_state);
      d = {lfsr_state[15:10], i[0], lfsr_state[8:0]};
      module_access <= lfsr_state[31:16];
      wr(module_stop_off, d);
      rd(module_stop_off, d);
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      chk("stop", module_stop, d);
      chk("access", module_access_ok, lfsr_state[31:16] & ~d);
      chk("conv", {15'h0, converter_stop}, {15'h0, d[conv_stop_bit]});
      @(posedge core_clk);
    end
    // Clock select codes 1..5 then 0
    for (int s = 0; s < 6; s++) begin
      d = 16'((s + 1) % 6);
      wr(standby_ctrl_off, d);
      repeat (80) @(posedge core_clk);
      count_en(64);
      chk("cpu div", n_cpu[15:0], 16'h40 >> d);
      chk("dtc div", n_dtc[15:0], 16'h40 >> d);
      chk("periph", n_per[15:0], 16'h40);
    end
    wr(standby_ctrl_off, 16'h0002);
    repeat (80) @(posedge core_clk);
    slow <= 1'b1;
    do_sleep();
    rd(status_off, 16'h1);
    count_en(32);
    chk("sleep cpu", n_cpu[15:0], 16'h0);
    wake(7'h04);
    rd(status_off, 16'h0);
    count_en(64);
    chk("sleep restore", n_cpu[15:0], 16'h10);
    slow <= 1'b0;
    wr(module_stop_off, 16'h5a5a);
    wr(standby_ctrl_off, 16'h0082);
    do_sleep();
    rd(status_off, 16'h2);
    chk("hold", {15'h0, port_hold}, 16'h1);
    wake(7'h08);
    // Settling after standby takes 16 cycles at code 0
    repeat (32'(settle_unit) + 8) @(posedge core_clk);
    rd(status_off, 16'h0);
    rd(module_stop_off, 16'h5a5a);
    count_en(64);
    chk("standby restore", n_cpu[15:0], 16'h10);
    // Watch mode, settling code 1
    wr(low_power_off, 16'h0004);
    wr(standby_ctrl_off, 16'h0090);
    do_sleep();
    rd(status_off, 16'h3);
    @(negedge core_clk);
    chk("watch clks", {periph_clk_en, watchdog2_clk_en, port_hold}, 16'h3);
    @(posedge core_clk);
    wake_enable <= 7'h7b;
    wake(7'h04);
    rd(status_off, 16'h3);
    cpu_mask <= 1'b1;
    wake(7'h08);
    rd(status_off, 16'h3);
    cpu_mask <= 1'b0;
    wake_enable <= '1;
    wake_set <= 7'h02;
    n_cpu = 0;
    while (interrupt_start !== 1'b1 && n_cpu < 500) begin
      @(posedge core_clk);
      n_cpu++;
    end
    chk("settle", {15'h0, n_cpu >= 32 && n_cpu <= 40}, 16'h1);
    wake_set <= '0;
    rd(status_off, 16'h0);
    wr(low_power_off, 16'h0005);
    do_sleep();
    wake(7'h01);
    rd(status_off, 16'h5);
    wr(standby_ctrl_off, 16'h0003);
    repeat (80) @(posedge core_clk);
    watchdog_reset <= 1'b1;
    @(posedge core_clk);
    watchdog_reset <= 1'b0;
    @(posedge core_clk);
    rd(standby_ctrl_off, 16'h0);
    rd(status_off, 16'h0);
    count_en(64);
    chk("wdt cancel", n_cpu[15:0], 16'h40);
    // Hardware standby refuses writes and reloads stop bits
    wr(module_stop_off, 16'h0000);
    hardware_standby_pin_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("hw standby", {watchdog2_clk_en, periph_clk_en}, 16'h0);
    @(posedge core_clk);
    wr(module_stop_off, 16'h1234);
    hardware_standby_pin_n <= 1'b1;
    @(posedge core_clk);
    rd(module_stop_off, module_stop_reset);
    close_out();
  end
  // Watchdog against hangs
  initial begin
    #(40 * 20000);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
